// [hdl/vcore_consts.vh]
// Constants for the dual-issue vector core pipeline
`ifndef VCORE_CONSTS_VH
`define VCORE_CONSTS_VH

// Scalar operation classes
`define S_NOP 4'h0
`define S_ADD 4'h1
`define S_SUB 4'h2
`define S_LOAD 4'h3
`define S_STORE 4'h4
`define S_BEQ 4'h5
`define S_BNE 4'h6
`define S_JAL 4'h7
`define S_JALR 4'h8
`define S_BREAK 4'h9
`define S_MTC2 4'ha
`define S_MFC2 4'hb

// Vector operation classes
`define V_NOP 4'h0
`define V_ADD 4'h1
`define V_SUB 4'h2
`define V_ADDC 4'h3
`define V_SUBC 4'h4
`define V_LT 4'h5
`define V_EQ 4'h6
`define V_CH 4'h7
`define V_CL 4'h8
`define V_MRG 4'h9
`define V_MAC 4'ha

// Special scalar registers
`define REG_ZERO 5'h00
`define REG_LINK 5'h1f
`define LINK_STEP 12'h008

// Register bus map
`define RA_COMPARE 3'h0
`define RA_CARRY 3'h1
`define RA_EXT 3'h2
`define RA_STATUS 3'h3

// Status register fields
`define ST_HALT 0
`define ST_BREAK 1

// Vector register layout
`define VREG_W 128
`define ELEM_W 16
`define ACC_W 48
`define SLICES 8
`define MAC_LSB 16

`endif

// [hdl/vector_core.v]
// Dual-issue scalar/vector core: issue control, register files, pipelines, flags
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`include "vcore_consts.vh"

// Summary of operation
// (RQ1) Scalar register zero reads zero, ignores writes
// (RQ2) Jump-and-link writes return address to register 31
// (RQ3) Thirty-two vector registers, 128 bits, three views
// (RQ4) Element 0 and byte 0 at bit 127
// (RQ5) Eight slices elementwise, optional broadcast element operand
// (RQ6) Vector moves select data by byte index
// (RQ7) Each slice owns a 48-bit accumulator
// (RQ8) Multiply-accumulate writes accumulator bits to destination
// (RQ9) Compare flags: low ordinary/ge, high clip le
// (RQ10) Carry flags: low carry, high not-equal
// (RQ11) Add, subtract, select compares consume then clear carry
// (RQ12) High clip sets extension; low clip reads, clears
// (RQ13) Pair one scalar, one vector, in order
// (RQ14) Illegal instructions execute without any trap
// (RQ15) Scalar pipe: fetch, read, execute, memory, writeback
// (RQ16) Vector pipe: fetch, read, multiply, accumulate, writeback
// (RQ17) Vector destinations written four cycles after issue
// (RQ18) Loads ready after three cycles; arithmetic next cycle
// (RQ19) Load then store two later adds bubble
// (RQ20) Delay slot single, taken bubble, misaligned target single
// (RQ21) Reading marked destination stalls both units
// (RQ22) No incoming interrupts; break raises host interrupt
// (RQ23) Hazard mark released in writeback cycle
// (RQ24) Break also sets status condition bits
module vector_core (
	input wire mclk_i,
	input wire srst_i,
	input wire s_valid_i,
	input wire [3:0] s_op_i,
	input wire [4:0] s_rd_i,
	input wire [4:0] s_rs_i,
	input wire [4:0] s_rt_i,
	input wire [31:0] s_imm_i,
	input wire [11:0] s_pc_i,
	input wire [4:0] s_vreg_i,
	input wire [3:0] s_byte_i,
	input wire v_valid_i,
	input wire [3:0] v_op_i,
	input wire [4:0] v_vd_i,
	input wire [4:0] v_vs_i,
	input wire [4:0] v_vt_i,
	input wire [3:0] v_elem_i,
	input wire v_older_i,
	output wire issue_s_o,
	output wire issue_v_o,
	output wire redirect_o,
	output wire [11:0] redirect_pc_o,
	output wire mem_re_o,
	output wire mem_we_o,
	output wire [11:0] mem_addr_o,
	output wire [31:0] mem_wdata_o,
	input wire [31:0] mem_rdata_i,
	input wire [2:0] reg_addr_i,
	input wire [15:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output wire [15:0] reg_rdata_o,
	output wire coprocessor_break_interrupt_o,
	output wire halted_o
);

	reg [31:0] srf [0:31];
	reg [127:0] vrf [0:31];
	reg [31:0] s_busy_q;
	reg [31:0] v_busy_q;
	reg [15:0] cmp_q;
	reg [15:0] carry_q;
	reg [7:0] ext_q;
	reg halt_q;
	reg brk_q;
	reg irq_q;
	reg [15:0] rdata_q;
	reg ds_q;
	reg taken_pend_q;
	reg bubble_q;
	reg tgt_single_q;
	reg redirect_q;
	reg [11:0] redirect_pc_q;
	reg [1:0] ld_hist_q;
	// Scalar load / move-from pipe: memory and writeback stages
	reg ld1_q, ld1_mv_q, ld2_q, ld2_mv_q;
	reg [4:0] ld1_rd_q, ld2_rd_q;
	reg [31:0] ld1_mv_data_q, ld2_mv_data_q;
	reg [11:0] mem_addr_q;
	reg mem_we_q;
	reg [31:0] mem_wdata_q;
	// Move-to-vector pipe
	reg m1_q, m2_q, m3_q;
	reg [4:0] m1_reg_q, m2_reg_q, m3_reg_q;
	reg [3:0] m1_byte_q, m2_byte_q, m3_byte_q;
	reg [15:0] m1_data_q, m2_data_q, m3_data_q;
	// Vector pipe: multiply, accumulate, writeback
	reg p1_q, p2_q, p3_q;
	reg [3:0] p1_op_q, p2_op_q;
	reg [4:0] p1_vd_q, p2_vd_q, p3_vd_q;
	reg [127:0] p1_a_q, p1_b_q;

	// Scalar operand read; register zero is forced to zero
	wire [31:0] rs_val = (s_rs_i == `REG_ZERO) ? 32'h00000000 : srf[s_rs_i]; // RQ1
	wire [31:0] rt_val = (s_rt_i == `REG_ZERO) ? 32'h00000000 : srf[s_rt_i]; // RQ1
	wire is_ld = (s_op_i == `S_LOAD);
	wire is_st = (s_op_i == `S_STORE);
	wire is_mtc = (s_op_i == `S_MTC2);
	wire is_mfc = (s_op_i == `S_MFC2);
	wire is_br = (s_op_i == `S_BEQ) || (s_op_i == `S_BNE);
	wire is_jmp = (s_op_i == `S_JAL) || (s_op_i == `S_JALR);
	wire is_alu = (s_op_i == `S_ADD) || (s_op_i == `S_SUB);
	wire use_rs = is_alu || is_ld || is_st || is_br || (s_op_i == `S_JALR);
	wire use_rt = (s_op_i == `S_SUB) || is_st || is_br || is_mtc;
	wire [4:0] s_dst = is_jmp ? `REG_LINK : s_rd_i; // RQ2
	wire wr_s = is_alu || is_ld || is_mfc || is_jmp;

	// Hazard marks on destinations stall everything
	wire s_hz = s_valid_i && ((use_rs && s_busy_q[s_rs_i]) || (use_rt && s_busy_q[s_rt_i]) ||
		(wr_s && s_busy_q[s_dst]) || ((is_mtc || is_mfc) && v_busy_q[s_vreg_i])); // RQ21
	wire v_hz = v_valid_i && (v_op_i != `V_NOP) &&
		(v_busy_q[v_vs_i] || v_busy_q[v_vt_i] || v_busy_q[v_vd_i]); // RQ21
	wire ls_bub = s_valid_i && (is_st || is_mtc || is_mfc) && ld_hist_q[1]; // RQ19
	wire stall = halt_q || bubble_q || s_hz || v_hz || ls_bub; // RQ20 RQ21

	// Conflicts inside a pair force single issue of the older one
	wire both = s_valid_i && v_valid_i;
	wire pair_conf = both && (v_op_i != `V_NOP) &&
		((is_mfc && v_older_i && (v_vd_i == s_vreg_i)) ||
		(is_mtc && !v_older_i && ((v_vs_i == s_vreg_i) || (v_vt_i == s_vreg_i) ||
		(v_vd_i == s_vreg_i))));
	wire single = ds_q || tgt_single_q || pair_conf || ((is_br || is_jmp) && !v_older_i); // RQ20
	assign issue_s_o = !stall && s_valid_i && !(both && single && v_older_i); // RQ13
	assign issue_v_o = !stall && v_valid_i && !(both && single && !v_older_i); // RQ13
	wire any_issue = issue_s_o || issue_v_o;

	wire [31:0] alu_res = (s_op_i == `S_SUB) ? (rs_val - rt_val) : (rs_val + s_imm_i);
	wire [31:0] link_val = {20'h00000, s_pc_i + `LINK_STEP}; // RQ2
	wire br_taken = ((s_op_i == `S_BEQ) && (rs_val == rt_val)) ||
		((s_op_i == `S_BNE) && (rs_val != rt_val)) || is_jmp;
	wire [11:0] br_tgt = (s_op_i == `S_JALR) ? rs_val[11:0] : s_imm_i[11:0];

	// Byte-indexed view of a vector register, reading bits past byte 15 as zero
	wire [127:0] mv_src = vrf[s_vreg_i];
	wire [135:0] mv_shift = {mv_src, 8'h00} << {s_byte_i, 3'b000}; // RQ6
	wire [15:0] mv_half = mv_shift[135:120];

	wire [127:0] m_old = vrf[m3_reg_q];
	wire [127:0] m_mask = {16'hffff, 112'h0} >> {m3_byte_q, 3'b000}; // RQ6 RQ14
	wire [127:0] m_put = {m3_data_q, 112'h0} >> {m3_byte_q, 3'b000}; // RQ4
	wire [127:0] m_new = (m_old & ~m_mask) | m_put;

	wire [127:0] va_rd = vrf[v_vs_i];
	wire [127:0] vt_rd = vrf[v_vt_i];
	wire [127:0] vt_sh = vt_rd << {v_elem_i[2:0], 4'h0};
	// Scalar mode: broadcast one element of the second operand
	wire [127:0] vb_mux = v_elem_i[3] ? {8{vt_sh[127:112]}} : vt_rd; // RQ5 RQ16

	wire [7:0] cy_w, ne_w, ge_w, le_w, cond_w, ext_w;
	wire [127:0] p3_res_w;

	genvar n;
	generate
		for (n = 0; n < `SLICES; n = n + 1) begin : slice
			// Element n sits at the high end for n = 0
			wire [15:0] a = p1_a_q[127 - 16 * n -: 16]; // RQ4
			wire [15:0] b = p1_b_q[127 - 16 * n -: 16]; // RQ4
			wire [16:0] usum = {1'b0, a} + {1'b0, b};
			wire [16:0] udif = {1'b0, a} - {1'b0, b};
			wire [16:0] ssum = {a[15], a} + {b[15], b};
			wire [16:0] ssum_e = ssum + {16'h0000, ext_q[n] & (p1_op_q == `V_CL)}; // RQ12
			wire lt = $signed(a) < $signed(b);
			wire eq = (a == b);
			wire [15:0] cin = {15'h0000, carry_q[n]};
			reg [15:0] r;
			reg [31:0] prod_q;
			reg [15:0] p2_r_q;
			reg [15:0] p3_r_q;
			reg [47:0] acc_q;
			wire [47:0] acc_sum = acc_q + {{16{prod_q[31]}}, prod_q};
			assign cy_w[n] = (p1_op_q == `V_ADDC) ? usum[16] : udif[16]; // RQ10
			assign ne_w[n] = !eq; // RQ10
			assign ge_w[n] = !lt; // RQ9
			assign le_w[n] = ssum_e[16] || (ssum_e == 17'h00000); // RQ9
			assign ext_w[n] = (a[15] ^ b[15]) && (ssum == 17'h1ffff); // RQ12
			assign cond_w[n] = (p1_op_q == `V_LT) ? (lt || (eq && carry_q[n] && carry_q[n + 8]))
				: (eq && !carry_q[n + 8]); // RQ11
			always @* begin
				case (p1_op_q)
				`V_ADD: r = a + b + cin; // RQ5 RQ11
				`V_SUB: r = a - b - cin; // RQ11
				`V_ADDC: r = usum[15:0];
				`V_SUBC: r = udif[15:0];
				`V_LT, `V_EQ: r = cond_w[n] ? a : b;
				`V_MRG: r = cmp_q[n] ? a : b; // RQ9
				default: r = a;
				endcase
			end
			// Multiply stage, then accumulate stage, then writeback
			always @(posedge mclk_i) begin
				prod_q <= $signed(a) * $signed(b); // RQ16
				p2_r_q <= r;
				if (srst_i) begin
					acc_q <= 48'h000000000000;
				end else if (p2_q && (p2_op_q == `V_MAC)) begin
					acc_q <= acc_sum; // RQ7
				end else if (p2_q && (p2_op_q != `V_NOP)) begin
					acc_q <= {acc_q[47:16], p2_r_q}; // RQ7
				end
				p3_r_q <= (p2_op_q == `V_MAC) ? acc_sum[`MAC_LSB +: 16] : p2_r_q; // RQ8
			end
			assign p3_res_w[127 - 16 * n -: 16] = p3_r_q; // RQ3 RQ4
		end
	endgenerate

	// Register file writes
	always @(posedge mclk_i) begin
		if (issue_s_o && (is_alu || is_jmp) && (s_dst != `REG_ZERO)) begin
			srf[s_dst] <= is_jmp ? link_val : alu_res; // RQ1 RQ2 RQ18
		end
		if (ld2_q && (ld2_rd_q != `REG_ZERO)) begin
			srf[ld2_rd_q] <= ld2_mv_q ? ld2_mv_data_q : mem_rdata_i; // RQ1 RQ18
		end
		if (p3_q) begin
			vrf[p3_vd_q] <= p3_res_w; // RQ3 RQ17
		end
		if (m3_q) begin
			vrf[m3_reg_q] <= m_new; // RQ17
		end
	end

	// Pipeline stages; carry no reset so only valid bits need one
	always @(posedge mclk_i) begin
		ld1_rd_q <= s_dst;
		ld1_mv_q <= is_mfc;
		ld1_mv_data_q <= {{16{mv_half[15]}}, mv_half}; // RQ6
		ld2_rd_q <= ld1_rd_q;
		ld2_mv_q <= ld1_mv_q;
		ld2_mv_data_q <= ld1_mv_data_q;
		mem_addr_q <= alu_res[11:0]; // RQ15
		mem_wdata_q <= rt_val;
		m1_reg_q <= s_vreg_i;
		m1_byte_q <= s_byte_i;
		m1_data_q <= rt_val[15:0];
		m2_reg_q <= m1_reg_q;
		m2_byte_q <= m1_byte_q;
		m2_data_q <= m1_data_q;
		m3_reg_q <= m2_reg_q;
		m3_byte_q <= m2_byte_q;
		m3_data_q <= m2_data_q;
		p1_op_q <= v_op_i;
		p1_vd_q <= v_vd_i;
		p1_a_q <= va_rd;
		p1_b_q <= vb_mux;
		p2_op_q <= p1_op_q;
		p2_vd_q <= p1_vd_q;
		p3_vd_q <= p2_vd_q;
		if (srst_i) begin
			ld1_q <= 1'b0;
			ld2_q <= 1'b0;
			mem_we_q <= 1'b0;
			m1_q <= 1'b0;
			m2_q <= 1'b0;
			m3_q <= 1'b0;
			p1_q <= 1'b0;
			p2_q <= 1'b0;
			p3_q <= 1'b0;
		end else begin
			ld1_q <= issue_s_o && (is_ld || is_mfc); // RQ15 RQ18
			ld2_q <= ld1_q;
			mem_we_q <= issue_s_o && is_st; // RQ15
			m1_q <= issue_s_o && is_mtc; // RQ17
			m2_q <= m1_q;
			m3_q <= m2_q;
			p1_q <= issue_v_o && (v_op_i != `V_NOP); // RQ16
			p2_q <= p1_q;
			p3_q <= p2_q;
		end
	end

	// Hazard marks: set at issue, released in the writeback cycle
	always @(posedge mclk_i) begin
		if (srst_i) begin
			s_busy_q <= 32'h00000000;
			v_busy_q <= 32'h00000000;
		end else begin
			s_busy_q <= (s_busy_q & ~((ld2_q ? 32'h00000001 : 32'h00000000) << ld2_rd_q)) |
				((issue_s_o && (is_ld || is_mfc) && (s_dst != `REG_ZERO)) ?
				(32'h00000001 << s_dst) : 32'h00000000); // RQ21 RQ23
			v_busy_q <= (v_busy_q & ~((p3_q ? 32'h00000001 : 32'h00000000) << p3_vd_q)
				& ~((m3_q ? 32'h00000001 : 32'h00000000) << m3_reg_q)) |
				((issue_v_o && (v_op_i != `V_NOP)) ? (32'h00000001 << v_vd_i) : 32'h00000000) |
				((issue_s_o && is_mtc) ? (32'h00000001 << s_vreg_i) : 32'h00000000); // RQ21 RQ23
		end
	end

	// Branch sequencing, load/store spacing and break handling
	always @(posedge mclk_i) begin
		if (srst_i) begin
			ds_q <= 1'b0;
			taken_pend_q <= 1'b0;
			bubble_q <= 1'b0;
			tgt_single_q <= 1'b0;
			redirect_q <= 1'b0;
			redirect_pc_q <= 12'h000;
			ld_hist_q <= 2'b00;
			halt_q <= 1'b0;
			brk_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			ld_hist_q <= {ld_hist_q[0], issue_s_o && (is_ld || is_mtc || is_mfc)}; // RQ19
			redirect_q <= 1'b0;
			bubble_q <= 1'b0;
			if (issue_s_o && (is_br || is_jmp)) begin
				ds_q <= 1'b1; // RQ20
				taken_pend_q <= br_taken;
				redirect_pc_q <= br_tgt;
			end else if (any_issue) begin
				ds_q <= 1'b0;
				if (taken_pend_q) begin
					taken_pend_q <= 1'b0;
					redirect_q <= 1'b1;
					bubble_q <= 1'b1; // RQ20
					tgt_single_q <= redirect_pc_q[2]; // RQ20
				end else begin
					tgt_single_q <= 1'b0;
				end
			end
			// Break sets status bits and pulses the host interrupt; no trap taken
			irq_q <= issue_s_o && (s_op_i == `S_BREAK); // RQ22 RQ14
			if (issue_s_o && (s_op_i == `S_BREAK)) begin
				halt_q <= 1'b1; // RQ24
				brk_q <= 1'b1; // RQ24
			end else if (reg_wr_i && (reg_addr_i == `RA_STATUS)) begin
				halt_q <= halt_q & ~reg_wdata_i[`ST_HALT];
				brk_q <= brk_q & ~reg_wdata_i[`ST_BREAK];
			end
		end
	end

	// Flag registers; pipeline updates win over software writes
	always @(posedge mclk_i) begin
		if (srst_i) begin
			cmp_q <= 16'h0000;
			carry_q <= 16'h0000;
			ext_q <= 8'h00;
		end else begin
			if (p1_q && ((p1_op_q == `V_CH) || (p1_op_q == `V_CL))) begin
				cmp_q <= {le_w, ge_w}; // RQ9
			end else if (p1_q && ((p1_op_q == `V_LT) || (p1_op_q == `V_EQ))) begin
				cmp_q <= {8'h00, cond_w}; // RQ9
			end else if (reg_wr_i && (reg_addr_i == `RA_COMPARE)) begin
				cmp_q <= reg_wdata_i;
			end
			if (p1_q && ((p1_op_q == `V_ADDC) || (p1_op_q == `V_SUBC))) begin
				carry_q <= {ne_w, cy_w}; // RQ10
			end else if (p1_q && ((p1_op_q == `V_ADD) || (p1_op_q == `V_SUB) ||
				(p1_op_q == `V_LT) || (p1_op_q == `V_EQ))) begin
				carry_q <= 16'h0000; // RQ11
			end else if (reg_wr_i && (reg_addr_i == `RA_CARRY)) begin
				carry_q <= reg_wdata_i;
			end
			if (p1_q && (p1_op_q == `V_CH)) begin
				ext_q <= ext_w; // RQ12
			end else if (p1_q && (p1_op_q == `V_CL)) begin
				ext_q <= 8'h00; // RQ12
			end else if (reg_wr_i && (reg_addr_i == `RA_EXT)) begin
				ext_q <= reg_wdata_i[7:0];
			end
		end
	end

	// Register read port, data one cycle after the strobe
	always @(posedge mclk_i) begin
		if (srst_i) begin
			rdata_q <= 16'h0000;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
			`RA_COMPARE: rdata_q <= cmp_q;
			`RA_CARRY: rdata_q <= carry_q;
			`RA_EXT: rdata_q <= {8'h00, ext_q};
			`RA_STATUS: rdata_q <= {14'h0000, brk_q, halt_q};
			default: rdata_q <= 16'h0000;
			endcase
		end else begin
			rdata_q <= 16'h0000;
		end
	end

	assign reg_rdata_o = rdata_q;
	assign redirect_o = redirect_q;
	assign redirect_pc_o = redirect_pc_q;
	assign mem_re_o = ld1_q && !ld1_mv_q;
	assign mem_we_o = mem_we_q;
	assign mem_addr_o = mem_addr_q;
	assign mem_wdata_o = mem_wdata_q;
	assign coprocessor_break_interrupt_o = irq_q;
	assign halted_o = halt_q;

endmodule

// [tb/vector_core_chk.sv]
// Port checker for the vector core
`timescale 1ns/100ps
`include "vcore_consts.vh"
module vector_core_chk (
	input wire mclk_i,
	input wire srst_i,
	input wire s_valid_i,
	input wire [3:0] s_op_i,
	input wire [4:0] s_rs_i,
	input wire [31:0] s_imm_i,
	input wire issue_s_o,
	input wire issue_v_o,
	input wire redirect_o,
	input wire [11:0] redirect_pc_o,
	input wire mem_re_o,
	input wire mem_we_o,
	input wire [11:0] mem_addr_o,
	input wire coprocessor_break_interrupt_o,
	input wire halted_o
);
	logic [11:0] imm_q1;
	logic [11:0] imm_q2;
	wire go = issue_s_o && s_valid_i;
	always @(posedge mclk_i) begin
		imm_q1 <= s_imm_i[11:0];
		imm_q2 <= imm_q1;
	end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	property p_halt_stall;
		halted_o |-> !issue_s_o && !issue_v_o;
	endproperty
	a_halt_stall: assert property (p_halt_stall) else $error("issue while halted");
	property p_break_irq;
		go && s_op_i == `S_BREAK |=> coprocessor_break_interrupt_o && halted_o;
	endproperty
	a_break_irq: assert property (p_break_irq) else $error("break gave no interrupt");
	property p_irq_pulse;
		coprocessor_break_interrupt_o |=> !coprocessor_break_interrupt_o;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt not a pulse");
	property p_bubble;
		redirect_o |-> !issue_s_o && !issue_v_o;
	endproperty
	a_bubble: assert property (p_bubble) else $error("issue in taken bubble");
	property p_jump_target;
		go && s_op_i == `S_JAL ##1 issue_s_o |=> redirect_o && redirect_pc_o == imm_q2;
	endproperty
	a_jump_target: assert property (p_jump_target) else $error("bad redirect");
	property p_delay_single;
		go && s_op_i == `S_JAL |=> !(issue_s_o && issue_v_o);
	endproperty
	a_delay_single: assert property (p_delay_single) else $error("delay slot paired");
	property p_store_df;
		go && s_op_i == `S_STORE |=> mem_we_o && !mem_re_o;
	endproperty
	a_store_df: assert property (p_store_df) else $error("store not in memory stage");
	property p_load_df;
		go && s_op_i == `S_LOAD && s_rs_i == 5'h00 |=> mem_re_o && mem_addr_o == imm_q1;
	endproperty
	a_load_df: assert property (p_load_df) else $error("load address wrong");
	property p_load_store;
		go && s_op_i == `S_LOAD |-> ##2 !(go && s_op_i == `S_STORE);
	endproperty
	a_load_store: assert property (p_load_store) else $error("no load-store bubble");
	c_break: cover property (coprocessor_break_interrupt_o);
	c_redirect: cover property (redirect_o);
	c_load: cover property (mem_re_o);
endmodule
bind vector_core vector_core_chk chk_inst (.mclk_i(mclk_i), .srst_i(srst_i),
	.s_valid_i(s_valid_i), .s_op_i(s_op_i), .s_rs_i(s_rs_i), .s_imm_i(s_imm_i),
	.issue_s_o(issue_s_o), .issue_v_o(issue_v_o), .redirect_o(redirect_o),
	.redirect_pc_o(redirect_pc_o), .mem_re_o(mem_re_o), .mem_we_o(mem_we_o),
	.mem_addr_o(mem_addr_o), .coprocessor_break_interrupt_o(coprocessor_break_interrupt_o),
	.halted_o(halted_o));

// [tb/host_mem.sv]
// Data memory on the far side of the core
`timescale 1ns/100ps
module host_mem (
	input wire mclk_i,
	input wire mem_re_o,
	input wire mem_we_o,
	input wire [11:0] mem_addr_o,
	input wire [31:0] mem_wdata_o,
	output logic [31:0] mem_rdata_i
);
	logic [31:0] word_q [0:1023];
	initial mem_rdata_i = 32'h00000000;
	always @(posedge mclk_i) begin
		if (mem_we_o) begin
			word_q[mem_addr_o[11:2]] <= mem_wdata_o;
		end
		// Outside the answer cycle the bus toggles so stale data never looks valid
		if (mem_re_o) begin
			mem_rdata_i <= word_q[mem_addr_o[11:2]];
		end else begin
			mem_rdata_i <= ~mem_rdata_i;
		end
	end
endmodule

// [tb/test_dual_issue_vector_core_pipeline.sv]
// Self-checking bench for the dual-issue vector core
`timescale 1ns/100ps
`include "vcore_consts.vh"
module test_dual_issue_vector_core_pipeline;
	logic mclk_i = 0, srst_i = 1, s_valid_i = 0, v_valid_i = 0, reg_wr_i = 0, reg_rd_i = 0;
	logic [3:0] s_op_i = 0, v_op_i = 0;
	logic [4:0] s_rd_i = 0, s_rs_i = 0, s_rt_i = 0, v_vd_i = 0, v_vs_i = 0, v_vt_i = 0;
	logic [31:0] s_imm_i = 0, x = 32'he1fa;
	logic [11:0] s_pc_i = 0;
	logic [4:0] s_vreg_i = 0;
	logic [3:0] s_byte_i = 0, v_elem_i = 0;
	logic v_older_i = 0;
	logic [2:0] reg_addr_i = 0;
	logic [15:0] reg_wdata_i = 0;
	wire issue_s_o, issue_v_o, redirect_o, mem_re_o, mem_we_o, irq, halted_o;
	wire [11:0] redirect_pc_o, mem_addr_o;
	wire [31:0] mem_wdata_o, mem_rdata_i;
	wire [15:0] reg_rdata_o;
	int num_errors = 0, n_checks = 0, cyc = 0, c0, c1, i, sum, exp_flags;
	logic [31:0] m_reg [0:31];
	logic [15:0] m_vec [0:7];
	logic [31:0] m_mem [int];
	always #2 mclk_i = ~mclk_i;
	always @(posedge mclk_i) cyc <= cyc + 1;
	vector_core vector_core_inst (.mclk_i(mclk_i), .srst_i(srst_i), .s_valid_i(s_valid_i),
		.s_op_i(s_op_i), .s_rd_i(s_rd_i), .s_rs_i(s_rs_i), .s_rt_i(s_rt_i), .s_imm_i(s_imm_i),
		.s_pc_i(s_pc_i), .s_vreg_i(s_vreg_i), .s_byte_i(s_byte_i), .v_valid_i(v_valid_i),
		.v_op_i(v_op_i), .v_vd_i(v_vd_i), .v_vs_i(v_vs_i), .v_vt_i(v_vt_i),
		.v_elem_i(v_elem_i), .v_older_i(v_older_i), .issue_s_o(issue_s_o),
		.issue_v_o(issue_v_o), .redirect_o(redirect_o),
		.redirect_pc_o(redirect_pc_o), .mem_re_o(mem_re_o), .mem_we_o(mem_we_o),
		.mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.coprocessor_break_interrupt_o(irq), .halted_o(halted_o));
	host_mem host_mem_inst (.mclk_i(mclk_i), .mem_re_o(mem_re_o), .mem_we_o(mem_we_o),
		.mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i));
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task tally_and_finish;
		if (num_errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task chk(input [31:0] seen, input [31:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Every task below starts and ends just after a rising edge
	task wr(input [2:0] a, input [15:0] d);
		reg_wr_i <= 1; reg_addr_i <= a; reg_wdata_i <= d;
		@(posedge mclk_i); reg_wr_i <= 0;
		@(posedge mclk_i);
	endtask
	task rd(input [2:0] a, input [15:0] e);
		reg_rd_i <= 1; reg_addr_i <= a;
		@(posedge mclk_i); reg_rd_i <= 0;
		#1 chk(reg_rdata_o, e, "reg_rdata_o");
		@(posedge mclk_i);
	endtask
	task iss(input v, input [3:0] op, input [4:0] d, s, t, input [31:0] imm, output int c);
		int n;
		n = 0;
		s_valid_i <= !v; v_valid_i <= v; s_op_i <= op; v_op_i <= op; s_imm_i <= imm;
		s_rd_i <= d; v_vd_i <= d; s_rs_i <= s; v_vs_i <= s; s_rt_i <= t; v_vt_i <= t;
		do begin @(negedge mclk_i); n++; end while (!(v ? issue_v_o : issue_s_o) && n < 50);
		chk(n < 50, 1, "issue");
		c = cyc;
		@(posedge mclk_i);
		if (!v) case (op)
			`S_ADD: m_reg[d] = m_reg[s] + imm;
			`S_LOAD: m_reg[d] = m_mem[(m_reg[s] + imm) & 32'hffc];
			`S_STORE: m_mem[(m_reg[s] + imm) & 32'hffc] = m_reg[t];
			`S_JAL: m_reg[31] = {20'h0, s_pc_i + 12'h008};
			`S_MTC2: m_vec[s_byte_i / 2] = m_reg[t][15:0];
			`S_MFC2: m_reg[d] = {{16{m_vec[s_byte_i / 2][15]}}, m_vec[s_byte_i / 2]};
			default: ;
		endcase
		m_reg[0] = 0;
	endtask
	task idle;
		s_valid_i <= 0; v_valid_i <= 0;
	endtask
	task st(input [4:0] t, input [11:0] a, output int c);
		iss(0, `S_STORE, 0, 0, t, {20'h0, a}, c); idle;
		#1 chk(mem_we_o, 1, "mem_we_o");
		chk(mem_addr_o, a, "mem_addr_o");
		chk(mem_wdata_o, m_reg[t], "mem_wdata_o");
		@(posedge mclk_i);
	endtask
	initial begin
		repeat (4000) @(posedge mclk_i);
		num_errors++;
		tally_and_finish;
	end
	initial begin
		m_reg[0] = 0;
		repeat (2) @(posedge mclk_i);
		srst_i <= 0;
		@(posedge mclk_i);
		for (i = 0; i < 8; i++) rd(i[2:0], 16'h0000);
		wr(1, 16'hffff); rd(1, 16'hffff);
		wr(2, 16'hffff); rd(2, 16'h00ff);
		wr(5, 16'h1234); rd(5, 16'h0000);
		iss(1, `V_ADD, 3, 1, 2, 0, c0); iss(1, `V_SUB, 4, 3, 2, 0, c1); idle;
		chk(c1 - c0, 4, "vector gap");
		repeat (4) @(posedge mclk_i);
		rd(1, 16'h0000);
		iss(1, `V_CL, 5, 1, 2, 0, c0); idle;
		repeat (4) @(posedge mclk_i);
		rd(2, 16'h0000);
		x = lfsr(x);
		iss(0, `S_ADD, 5, 0, 0, x, c0); st(5, 12'h100, c1);
		chk(c1 - c0, 1, "forward gap");
		iss(0, `S_ADD, 0, 0, 0, x, c0); st(0, 12'h104, c1);
		iss(0, `S_LOAD, 6, 0, 0, 32'h100, c0); st(6, 12'h108, c1);
		chk(c1 - c0, 3, "load gap");
		iss(0, `S_LOAD, 7, 0, 0, 32'h104, c0); iss(0, `S_ADD, 8, 0, 0, 1, c1);
		st(5, 12'h10c, c1);
		chk(c1 - c0, 3, "store bubble");
		s_valid_i <= 1; s_op_i <= `S_ADD; s_rd_i <= 0; v_valid_i <= 1; v_op_i <= `V_NOP;
		v_older_i <= 1; s_pc_i <= 12'h040;
		@(negedge mclk_i) chk({issue_s_o, issue_v_o}, 2'b11, "pair issue");
		@(posedge mclk_i); v_older_i <= 0;
		iss(0, `S_JAL, 0, 0, 0, 32'h200, c0);
		s_op_i <= `S_NOP; v_valid_i <= 1; v_op_i <= `V_NOP;
		@(negedge mclk_i) chk({issue_s_o, issue_v_o}, 2'b10, "delay slot pair");
		@(posedge mclk_i); idle;
		#1 chk(redirect_o, 1, "redirect_o");
		chk(redirect_pc_o, 12'h200, "redirect_pc_o");
		@(posedge mclk_i);
		st(31, 12'h110, c0);
		// Fill v1 one element at a time by byte index, then read back elements 3 and 0
		for (i = 0; i < 8; i++) begin
			x = lfsr(x);
			iss(0, `S_ADD, 10, 0, 0, x, c0);
			s_vreg_i <= 5'h01; s_byte_i <= {i[2:0], 1'b0};
			iss(0, `S_MTC2, 0, 0, 10, 0, c0);
		end
		s_byte_i <= 4'h6;
		iss(0, `S_MTC2, 0, 0, 10, 0, c0); iss(0, `S_MFC2, 11, 0, 0, 0, c1);
		chk(c1 - c0, 4, "move to vector gap");
		s_byte_i <= 4'h0;
		iss(0, `S_MFC2, 12, 0, 0, 0, c0); st(12, 12'h114, c1);
		chk(c1 - c0, 3, "move from vector gap");
		st(11, 12'h118, c0);
		exp_flags = 0;
		for (i = 0; i < 8; i++) begin
			sum = m_vec[i] + m_vec[3];
			exp_flags[i] = sum[16];
			exp_flags[i + 8] = m_vec[i] != m_vec[3];
		end
		v_elem_i <= 4'hb;
		iss(1, `V_ADDC, 2, 1, 1, 0, c0); idle;
		repeat (2) @(posedge mclk_i);
		rd(1, exp_flags[15:0]);
		iss(1, `V_EQ, 3, 1, 1, 0, c0); idle;
		v_elem_i <= 4'h0;
		repeat (2) @(posedge mclk_i);
		rd(0, {8'h00, ~exp_flags[15:8]});
		rd(1, 16'h0000);
		iss(0, `S_BREAK, 0, 0, 0, 0, c0); idle;
		#1 chk(irq, 1, "break interrupt");
		chk(halted_o, 1, "halted_o");
		@(posedge mclk_i);
		s_valid_i <= 1; s_op_i <= `S_ADD; s_rd_i <= 9;
		@(negedge mclk_i) chk(issue_s_o, 0, "issue while halted");
		@(posedge mclk_i); idle;
		rd(3, 16'h0003);
		wr(3, 16'h0003);
		iss(0, `S_ADD, 9, 0, 0, 2, c0); idle;
		@(posedge mclk_i);
		rd(3, 16'h0000);
		tally_and_finish;
	end
endmodule
